// File: hdl/acc_pkg.sv
// constants and types shared by the comparator control block
package acc_pkg;
    localparam int CHAN_W          = 3;
    localparam int PERIOD_W        = 8;
    localparam int CNT_W           = 3;
    localparam int LEVEL_W         = 8;
    localparam int FLAG_W          = 2;
    localparam int FLAG_RISE_BIT   = 0;
    localparam int FLAG_FALL_BIT   = 1;
    localparam logic [CNT_W-1:0] FILT_OFF = 3'h0;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 8'h00;
    localparam logic [FLAG_W-1:0]   FLAGS_RST  = 2'h0;
    localparam int RESULT_W        = 8;
    localparam int DEPTH_ADDR_W    = 1;

    typedef enum logic [1:0] {
        ACC_FILT_IDLE   = 2'b00,
        ACC_FILT_COUNT  = 2'b01,
        ACC_FILT_STABLE = 2'b10
    } acc_filt_state_t;
endpackage : acc_pkg

// File: hdl/acc_result_reg.sv
// result holding register that a dma engine reads at a fixed location
`timescale 1ns/100ps
module acc_result_reg
    import acc_pkg::*;
#(
    parameter int WIDTH = RESULT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write side
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side
    output logic      [WIDTH-1:0] rd_data
);
    initial begin
        if (WIDTH < 1) $error("acc_result_reg: WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (wr_en) begin
            rd_data <= wr_data;
        end
    end
endmodule : acc_result_reg

// File: hdl/acc_control.sv
// digital control and output conditioning around an analog comparator
`timescale 1ns/100ps

// What this block does
// - equal plus and minus channel selections disable the comparator automatically
// - eight bit period divides the bus clock into the filter sample tick
// - new output accepted only after programmed count of agreeing samples; zero bypasses
// - external sample mode uses the external sample strobe instead of divider tick
// - invert setting complements the raw result for all downstream logic
// - output pin carries the selected result only while pin enable is set
// - current comparator output readable as one bit at any time
// - window enable gates the result with the window signal, else bypassed
// - rise and fall flags readable as a mask and cleared by mask
// - interrupt enabled separately for rising and falling edges
// - dma request enabled per edge; result held in a fixed register
// - reference dac has enable, supply select and eight bit level code
// - output source selects filtered result or unfiltered windowed result
// - window falling either holds last latched value or forces zero
// - rise flag sets on rising output, fall flag on falling; both allowed
// - with dma enabled an enabled edge requests dma instead of interrupt
module acc_control
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic                CLK,
    input  wire logic                RST_N,
    // analog comparator interface
    input  wire logic                COMPARE_RAW,
    output logic                     COMPARE_ENABLE_OUT,
    // configuration
    input  wire logic                MODULE_ENABLE,
    input  wire logic [CHAN_W-1:0]   PLUS_CHANNEL,
    input  wire logic [CHAN_W-1:0]   MINUS_CHANNEL,
    input  wire logic                INVERT_ENABLE,
    input  wire logic                WINDOW_ENABLE,
    input  wire logic                WINDOW_ZERO_MODE,
    input  wire logic                EXT_SAMPLE_ENABLE,
    input  wire logic [CNT_W-1:0]    FILTER_COUNT,
    input  wire logic [PERIOD_W-1:0] FILTER_PERIOD,
    input  wire logic                OUTPUT_SRC_RAW,
    input  wire logic                PIN_ENABLE,
    // external pins
    input  wire logic                WINDOW_IN,
    input  wire logic                SAMPLE_IN,
    output logic                     COMPARE_OUT_PIN,
    // status and events
    output logic                     FILTERED_COMPARE_RESULT,
    output logic                     WINDOWED_RAW_RESULT,
    output logic [FLAG_W-1:0]        COMPARE_STATUS_CONTROL,
    input  wire logic [FLAG_W-1:0]   FLAG_CLEAR_MASK,
    input  wire logic                FLAG_CLEAR_STROBE,
    input  wire logic                RISE_IRQ_ENABLE,
    input  wire logic                FALL_IRQ_ENABLE,
    input  wire logic                DMA_REQUEST_ENABLE,
    output logic                     IRQ_OUT,
    output logic                     DMA_REQ_OUT,
    output logic [RESULT_W-1:0]      RESULT_WORD,
    // reference dac
    input  wire logic                DAC_ENABLE,
    input  wire logic                DAC_SUPPLY_SEL,
    input  wire logic [LEVEL_W-1:0]  DAC_LEVEL,
    output logic                     DAC_ENABLE_OUT,
    output logic                     DAC_SUPPLY_OUT,
    output logic [LEVEL_W-1:0]       DAC_LEVEL_OUT
);
    // reset release synchroniser
    logic rst_meta_q, rst_sync_q, rst_n;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // pin and analog inputs pass two flops; stage one feeds only stage two
    logic [2:0] in_meta_q, in_sync_q;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_q <= 3'h0;
            in_sync_q <= 3'h0;
        end else begin
            in_meta_q <= {SAMPLE_IN, WINDOW_IN, COMPARE_RAW};
            in_sync_q <= in_meta_q;
        end
    end
    logic raw_s, window_s, sample_s;
    assign raw_s    = in_sync_q[0];
    assign window_s = in_sync_q[1];
    assign sample_s = in_sync_q[2];

    // comparator is forced off when both inputs name one channel
    logic cmp_active;
    assign cmp_active = MODULE_ENABLE && (PLUS_CHANNEL != MINUS_CHANNEL);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            COMPARE_ENABLE_OUT <= 1'b0;
        end else begin
            COMPARE_ENABLE_OUT <= cmp_active;
        end
    end

    // polarity; a disabled comparator reads as zero
    logic polar;
    assign polar = cmp_active && (raw_s ^ INVERT_ENABLE);

    // window stage: latch follows while window high, then hold or zero
    logic win_latch_q, windowed_q;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            win_latch_q   <= 1'b0;
        end else begin
            if (window_s) begin
                win_latch_q <= polar;
            end
        end
    end
    logic windowed_d;
    always_comb begin
        if (!WINDOW_ENABLE) begin
            windowed_d = polar;
        end else if (window_s) begin
            windowed_d = polar;
        end else if (WINDOW_ZERO_MODE) begin
            windowed_d = 1'b0;
        end else begin
            windowed_d = win_latch_q;
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            windowed_q <= 1'b0;
        end else begin
            windowed_q <= windowed_d;
        end
    end
    assign WINDOWED_RAW_RESULT = windowed_q;

    // sample tick divider; period zero ticks every cycle
    logic [PERIOD_W-1:0] div_q;
    logic                div_tick;
    assign div_tick = (div_q == FILTER_PERIOD);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= PERIOD_RST;
        end else if (div_tick || div_q > FILTER_PERIOD) begin
            div_q <= PERIOD_RST;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // external strobe counts on its rising edge only
    logic sample_prev_q, sample_tick;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sample_prev_q <= 1'b0;
        end else begin
            sample_prev_q <= sample_s;
        end
    end
    assign sample_tick = EXT_SAMPLE_ENABLE ? (sample_s && !sample_prev_q) : div_tick;

    // agreement filter
    acc_filt_state_t  fstate_q;
    logic [CNT_W-1:0] agree_q;
    logic             filt_q, cand_q;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fstate_q <= ACC_FILT_IDLE;
            agree_q  <= 3'h0;
            filt_q   <= 1'b0;
            cand_q   <= 1'b0;
        end else if (FILTER_COUNT == FILT_OFF) begin
            fstate_q <= ACC_FILT_IDLE;
            agree_q  <= 3'h0;
            filt_q   <= windowed_q;
        end else if (sample_tick) begin
            case (fstate_q)
                ACC_FILT_IDLE, ACC_FILT_STABLE: begin
                    if (windowed_q != filt_q) begin
                        cand_q <= windowed_q;
                        if (FILTER_COUNT == 3'h1) begin
                            filt_q   <= windowed_q;
                            fstate_q <= ACC_FILT_STABLE;
                        end else begin
                            agree_q  <= 3'h1;
                            fstate_q <= ACC_FILT_COUNT;
                        end
                    end
                end
                ACC_FILT_COUNT: begin
                    if (windowed_q != cand_q) begin
                        // disagreement restarts the run
                        fstate_q <= ACC_FILT_STABLE;
                        agree_q  <= 3'h0;
                    end else if (agree_q + 3'h1 >= FILTER_COUNT) begin
                        filt_q   <= cand_q;
                        agree_q  <= 3'h0;
                        fstate_q <= ACC_FILT_STABLE;
                    end else begin
                        agree_q <= agree_q + 3'h1;
                    end
                end
                default: begin
                    fstate_q <= ACC_FILT_IDLE;
                end
            endcase
        end
    end
    assign FILTERED_COMPARE_RESULT = filt_q;

    // output source and pin
    logic sel_out, sel_prev_q;
    assign sel_out = OUTPUT_SRC_RAW ? windowed_q : filt_q;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            COMPARE_OUT_PIN <= 1'b0;
            sel_prev_q      <= 1'b0;
        end else begin
            COMPARE_OUT_PIN <= PIN_ENABLE && sel_out;
            sel_prev_q      <= sel_out;
        end
    end

    // edge flags: set wins over a simultaneous clear
    logic rise_ev, fall_ev;
    assign rise_ev = sel_out && !sel_prev_q;
    assign fall_ev = !sel_out && sel_prev_q;
    logic [FLAG_W-1:0] flags_q, ev_vec, clr_vec;
    assign ev_vec  = {fall_ev, rise_ev};
    assign clr_vec = FLAG_CLEAR_STROBE ? FLAG_CLEAR_MASK : FLAGS_RST;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= (flags_q & ~clr_vec) | ev_vec;
        end
    end
    assign COMPARE_STATUS_CONTROL = flags_q;

    // request routing
    logic pend;
    assign pend = (flags_q[FLAG_RISE_BIT] && RISE_IRQ_ENABLE)
               || (flags_q[FLAG_FALL_BIT] && FALL_IRQ_ENABLE);
    assign IRQ_OUT     = pend && !DMA_REQUEST_ENABLE;
    assign DMA_REQ_OUT = pend && DMA_REQUEST_ENABLE;

    // result register for dma reads
    acc_result_reg #(.WIDTH(RESULT_W)) u_result (
        .clk     (CLK),
        .rst_n   (rst_n),
        .wr_en   (1'b1),
        .wr_data ({5'h00, flags_q, sel_out}),
        .rd_data (RESULT_WORD)
    );

    // reference dac controls
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            DAC_ENABLE_OUT <= 1'b0;
            DAC_SUPPLY_OUT <= 1'b0;
            DAC_LEVEL_OUT  <= 8'h00;
        end else begin
            DAC_ENABLE_OUT <= DAC_ENABLE;
            DAC_SUPPLY_OUT <= DAC_SUPPLY_SEL;
            DAC_LEVEL_OUT  <= DAC_LEVEL;
        end
    end

    // checks
    chk_same_chan_off: assert property (@(posedge CLK) disable iff (!rst_n)
        (PLUS_CHANNEL == MINUS_CHANNEL) |=> !COMPARE_ENABLE_OUT)
        else $error("comparator not disabled on equal channels");
    chk_pin_gated: assert property (@(posedge CLK) disable iff (!rst_n)
        !PIN_ENABLE |=> !COMPARE_OUT_PIN)
        else $error("pin driven while disabled");
    chk_flag_sticky: assert property (@(posedge CLK) disable iff (!rst_n)
        (flags_q[0] && !(FLAG_CLEAR_STROBE && FLAG_CLEAR_MASK[0])) |=> flags_q[0])
        else $error("rise flag lost without clear");
    chk_rise_sets: assert property (@(posedge CLK) disable iff (!rst_n)
        rise_ev |=> flags_q[FLAG_RISE_BIT])
        else $error("rise flag not set");
    chk_fall_sets: assert property (@(posedge CLK) disable iff (!rst_n)
        fall_ev |=> flags_q[FLAG_FALL_BIT])
        else $error("fall flag not set");
    chk_dma_not_irq: assert property (@(posedge CLK) disable iff (!rst_n)
        DMA_REQUEST_ENABLE |-> !IRQ_OUT)
        else $error("interrupt raised while dma enabled");
    chk_irq_cause: assert property (@(posedge CLK) disable iff (!rst_n)
        IRQ_OUT |-> ((flags_q[0] && RISE_IRQ_ENABLE) || (flags_q[1] && FALL_IRQ_ENABLE)))
        else $error("interrupt without enabled flag");
    chk_filt_bypass: assert property (@(posedge CLK) disable iff (!rst_n)
        (FILTER_COUNT == FILT_OFF) |=> (filt_q == $past(windowed_q)))
        else $error("filter not bypassed");
    chk_win_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        (WINDOW_ENABLE && WINDOW_ZERO_MODE && !window_s) |=> !windowed_q)
        else $error("window zero mode not zero");
    chk_div_period: assert property (@(posedge CLK) disable iff (!rst_n)
        div_tick && $stable(FILTER_PERIOD) |=> (div_q == 8'h00))
        else $error("divider not restarted");
endmodule : acc_control

// File: test/acc_control_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %0t %s", $time, msg); end end
module acc_control_test;
    import acc_pkg::*;
    logic                CLK, RST_N, COMPARE_RAW, MODULE_ENABLE, INVERT_ENABLE, WINDOW_ENABLE;
    logic                WINDOW_ZERO_MODE, EXT_SAMPLE_ENABLE, OUTPUT_SRC_RAW, PIN_ENABLE;
    logic                WINDOW_IN, SAMPLE_IN, FLAG_CLEAR_STROBE, RISE_IRQ_ENABLE;
    logic                FALL_IRQ_ENABLE, DMA_REQUEST_ENABLE, DAC_ENABLE, DAC_SUPPLY_SEL;
    logic                COMPARE_ENABLE_OUT, COMPARE_OUT_PIN, FILTERED_COMPARE_RESULT;
    logic                WINDOWED_RAW_RESULT, IRQ_OUT, DMA_REQ_OUT, DAC_ENABLE_OUT;
    logic                DAC_SUPPLY_OUT;
    logic [CHAN_W-1:0]   PLUS_CHANNEL, MINUS_CHANNEL;
    logic [CNT_W-1:0]    FILTER_COUNT;
    logic [PERIOD_W-1:0] FILTER_PERIOD;
    logic [FLAG_W-1:0]   COMPARE_STATUS_CONTROL, FLAG_CLEAR_MASK;
    logic [RESULT_W-1:0] RESULT_WORD;
    logic [LEVEL_W-1:0]  DAC_LEVEL, DAC_LEVEL_OUT;
    int                  fails = 0;
    int                  total_checks = 0;

    acc_control acc_control_inst (
        .CLK(CLK), .RST_N(RST_N), .COMPARE_RAW(COMPARE_RAW),
        .COMPARE_ENABLE_OUT(COMPARE_ENABLE_OUT), .MODULE_ENABLE(MODULE_ENABLE),
        .PLUS_CHANNEL(PLUS_CHANNEL), .MINUS_CHANNEL(MINUS_CHANNEL),
        .INVERT_ENABLE(INVERT_ENABLE), .WINDOW_ENABLE(WINDOW_ENABLE),
        .WINDOW_ZERO_MODE(WINDOW_ZERO_MODE), .EXT_SAMPLE_ENABLE(EXT_SAMPLE_ENABLE),
        .FILTER_COUNT(FILTER_COUNT), .FILTER_PERIOD(FILTER_PERIOD),
        .OUTPUT_SRC_RAW(OUTPUT_SRC_RAW), .PIN_ENABLE(PIN_ENABLE), .WINDOW_IN(WINDOW_IN),
        .SAMPLE_IN(SAMPLE_IN), .COMPARE_OUT_PIN(COMPARE_OUT_PIN),
        .FILTERED_COMPARE_RESULT(FILTERED_COMPARE_RESULT),
        .WINDOWED_RAW_RESULT(WINDOWED_RAW_RESULT),
        .COMPARE_STATUS_CONTROL(COMPARE_STATUS_CONTROL), .FLAG_CLEAR_MASK(FLAG_CLEAR_MASK),
        .FLAG_CLEAR_STROBE(FLAG_CLEAR_STROBE), .RISE_IRQ_ENABLE(RISE_IRQ_ENABLE),
        .FALL_IRQ_ENABLE(FALL_IRQ_ENABLE), .DMA_REQUEST_ENABLE(DMA_REQUEST_ENABLE),
        .IRQ_OUT(IRQ_OUT), .DMA_REQ_OUT(DMA_REQ_OUT), .RESULT_WORD(RESULT_WORD),
        .DAC_ENABLE(DAC_ENABLE), .DAC_SUPPLY_SEL(DAC_SUPPLY_SEL), .DAC_LEVEL(DAC_LEVEL),
        .DAC_ENABLE_OUT(DAC_ENABLE_OUT), .DAC_SUPPLY_OUT(DAC_SUPPLY_OUT),
        .DAC_LEVEL_OUT(DAC_LEVEL_OUT)
    );

    always #5 CLK = ~CLK;

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc

    // seven edges cover the five-edge input to pin path
    task automatic set_raw(input logic v);
        COMPARE_RAW = v;
        cyc(7);
    endtask : set_raw

    task automatic clear_flags(input logic [FLAG_W-1:0] m);
        FLAG_CLEAR_MASK   = m;
        FLAG_CLEAR_STROBE = 1'b1;
        cyc(1);
        FLAG_CLEAR_STROBE = 1'b0;
        cyc(2);
    endtask : clear_flags

    task automatic t_invert;
        set_raw(1'b1);
        `CHK(FILTERED_COMPARE_RESULT, 1'b1, "filtered")
        `CHK(RESULT_WORD[0], 1'b1, "result bit")
        `CHK(COMPARE_OUT_PIN, 1'b1, "pin")
        INVERT_ENABLE = 1'b1;
        cyc(7);
        `CHK({WINDOWED_RAW_RESULT, FILTERED_COMPARE_RESULT, COMPARE_OUT_PIN}, 3'h0, "inv")
        INVERT_ENABLE = 1'b0;
        PIN_ENABLE    = 1'b0;
        cyc(7);
        `CHK({FILTERED_COMPARE_RESULT, COMPARE_OUT_PIN}, 2'h2, "pin off")
        PIN_ENABLE = 1'b1;
        cyc(7);
        `CHK(COMPARE_OUT_PIN, 1'b1, "pin on")
        $display("test invert done");
    endtask : t_invert

    task automatic t_flags;
        set_raw(1'b0);
        clear_flags(2'h3);
        `CHK(COMPARE_STATUS_CONTROL, 2'h0, "cleared")
        set_raw(1'b1);
        cyc(10);
        `CHK(COMPARE_STATUS_CONTROL, 2'h1, "rise flag")
        `CHK(RESULT_WORD, 8'h03, "result word")
        for (int i = 0; i < 4; i++) begin
            {FALL_IRQ_ENABLE, RISE_IRQ_ENABLE} = i[1:0];
            cyc(2);
            `CHK(IRQ_OUT, i[0], "irq rise")
        end
        set_raw(1'b0);
        `CHK(COMPARE_STATUS_CONTROL, 2'h3, "both flags")
        `CHK(RESULT_WORD, 8'h06, "result word")
        DMA_REQUEST_ENABLE = 1'b1;
        cyc(2);
        `CHK({DMA_REQ_OUT, IRQ_OUT}, 2'h2, "dma not irq")
        clear_flags(2'h1);
        `CHK(COMPARE_STATUS_CONTROL, 2'h2, "mask clear")
        {FALL_IRQ_ENABLE, RISE_IRQ_ENABLE} = 2'h1;
        cyc(2);
        `CHK({DMA_REQ_OUT, IRQ_OUT}, 2'h0, "rise only")
        {FALL_IRQ_ENABLE, RISE_IRQ_ENABLE, DMA_REQUEST_ENABLE} = 3'h0;
        clear_flags(2'h3);
        $display("test flags done");
    endtask : t_flags

    task automatic t_window;
        set_raw(1'b1);
        {WINDOW_ENABLE, WINDOW_IN, WINDOW_ZERO_MODE} = 3'h6;
        cyc(7);
        `CHK(WINDOWED_RAW_RESULT, 1'b1, "window open")
        WINDOW_IN = 1'b0;
        cyc(4);
        set_raw(1'b0);
        `CHK(WINDOWED_RAW_RESULT, 1'b1, "hold")
        WINDOW_IN = 1'b1;
        set_raw(1'b1);
        {WINDOW_IN, WINDOW_ZERO_MODE} = 2'h1;
        cyc(7);
        `CHK(WINDOWED_RAW_RESULT, 1'b0, "forced zero")
        WINDOW_ENABLE = 1'b0;
        cyc(7);
        `CHK(WINDOWED_RAW_RESULT, 1'b1, "bypass")
        $display("test window done");
    endtask : t_window

    // a tick every 21 edges, three ticks must agree before the result moves
    task automatic t_filter;
        set_raw(1'b0);
        FILTER_PERIOD = 8'h14;
        FILTER_COUNT  = 3'h3;
        cyc(3);
        COMPARE_RAW = 1'b1;
        cyc(8);
        `CHK({WINDOWED_RAW_RESULT, FILTERED_COMPARE_RESULT}, 2'h2, "filter hold")
        OUTPUT_SRC_RAW = 1'b1;
        cyc(4);
        `CHK(COMPARE_OUT_PIN, 1'b1, "raw source")
        OUTPUT_SRC_RAW = 1'b0;
        cyc(4);
        `CHK(COMPARE_OUT_PIN, 1'b0, "filtered source")
        cyc(24);
        `CHK(FILTERED_COMPARE_RESULT, 1'b0, "two periods")
        cyc(40);
        `CHK(FILTERED_COMPARE_RESULT, 1'b1, "accepted")
        $display("test filter done");
    endtask : t_filter

    task automatic t_ext;
        {EXT_SAMPLE_ENABLE, FILTER_COUNT, FILTER_PERIOD} = {1'b1, 3'h2, 8'h00};
        COMPARE_RAW = 1'b0;
        cyc(30);
        `CHK(FILTERED_COMPARE_RESULT, 1'b1, "no strobe")
        repeat (4) begin
            SAMPLE_IN = 1'b1;
            cyc(3);
            SAMPLE_IN = 1'b0;
            cyc(3);
        end
        cyc(5);
        `CHK(FILTERED_COMPARE_RESULT, 1'b0, "strobed")
        {COMPARE_RAW, FILTER_COUNT} = 4'h9;
        cyc(5);
        `CHK(FILTERED_COMPARE_RESULT, 1'b0, "single waits")
        SAMPLE_IN = 1'b1;
        cyc(3);
        SAMPLE_IN = 1'b0;
        cyc(3);
        `CHK(FILTERED_COMPARE_RESULT, 1'b1, "single sample")
        {EXT_SAMPLE_ENABLE, FILTER_COUNT} = 4'h0;
        $display("test ext done");
    endtask : t_ext

    task automatic t_misc;
        MINUS_CHANNEL = PLUS_CHANNEL;
        set_raw(1'b1);
        `CHK({COMPARE_ENABLE_OUT, FILTERED_COMPARE_RESULT}, 2'h0, "same chan")
        MINUS_CHANNEL = 3'h5;
        cyc(7);
        `CHK({COMPARE_ENABLE_OUT, FILTERED_COMPARE_RESULT}, 2'h3, "chan ok")
        {DAC_ENABLE, DAC_SUPPLY_SEL, DAC_LEVEL} = {2'h3, 8'hA5};
        cyc(2);
        `CHK({DAC_ENABLE_OUT, DAC_SUPPLY_OUT, DAC_LEVEL_OUT}, 10'h3A5, "dac")
        {DAC_ENABLE, DAC_SUPPLY_SEL, DAC_LEVEL} = {2'h1, 8'hFF};
        cyc(2);
        `CHK({DAC_ENABLE_OUT, DAC_SUPPLY_OUT, DAC_LEVEL_OUT}, 10'h1FF, "dac")
        // shutdown order: comparator off first, the clock would stop only after this
        MODULE_ENABLE = 1'b0;
        cyc(2);
        `CHK(COMPARE_ENABLE_OUT, 1'b0, "shutdown")
        $display("test misc done");
    endtask : t_misc

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        {CLK, RST_N, COMPARE_RAW, INVERT_ENABLE, WINDOW_ENABLE, WINDOW_ZERO_MODE} = 6'h0;
        {EXT_SAMPLE_ENABLE, OUTPUT_SRC_RAW, WINDOW_IN, SAMPLE_IN, FLAG_CLEAR_STROBE} = 5'h0;
        {RISE_IRQ_ENABLE, FALL_IRQ_ENABLE, DMA_REQUEST_ENABLE, DAC_ENABLE} = 4'h0;
        {MODULE_ENABLE, PIN_ENABLE, DAC_SUPPLY_SEL, FLAG_CLEAR_MASK} = 5'h18;
        {PLUS_CHANNEL, MINUS_CHANNEL} = 6'h1A;
        FILTER_COUNT  = FILT_OFF;
        FILTER_PERIOD = 8'h00;
        DAC_LEVEL = 8'h00;
        cyc(2);
        RST_N = 1'b1;
        cyc(3);
        `CHK(COMPARE_STATUS_CONTROL, FLAGS_RST, "reset flags")
        t_invert();
        t_flags();
        t_window();
        t_filter();
        t_ext();
        t_misc();
        complete_run();
    end

    // the whole sequence needs well under a thousand edges
    initial begin
        repeat (5000) @(posedge CLK);
        fails++;
        complete_run();
    end
endmodule : acc_control_test
